// ---- core/ssrs_pkg.sv ----
// constants and state type shared by the supply reset supervisor
package ssrs_pkg;
    // rc oscillator rate and power-up delay
    localparam int unsigned RC_FREQ_HZ       = 7600000;
    localparam int unsigned PWRUP_DELAY_US   = 8600;
    // power-up delay in oscillator cycles, rounded down
    localparam int unsigned PWRUP_CYCLES     =
        (RC_FREQ_HZ / 1000) * PWRUP_DELAY_US / 1000;
    localparam int unsigned PWRUP_CNT_W      = 17;
    // field widths and reset values
    localparam int unsigned LEVEL_W          = 2;
    localparam logic [1:0]  CORE_RESET_POR   = 2'h0;
    localparam logic [1:0]  CORE_WARN_POR    = 2'h0;
    localparam logic [1:0]  IO_WARN_POR      = 2'h0;
    // processor fetch address after reset
    localparam logic [15:0] RESET_VECTOR     = 16'h8000;
    localparam int unsigned SYNC_STAGES      = 2;
    // supervisor states, one-hot
    typedef enum logic [3:0]
    {
        SSRS_OFF    = 4'h1,
        SSRS_POR    = 4'h2,
        SSRS_COUNT  = 4'h4,
        SSRS_RUN    = 4'h8
    } ssrs_state_e;
endpackage

// ---- core/ssrs_sync.sv ----
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module ssrs_sync
    import ssrs_pkg::*;
#(
    parameter logic INIT = 1'b0
)
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_r;     // first stage, read only by the second
    logic meta_nxt;   // next first stage
    logic sync_r;     // second stage
    logic sync_nxt;   // next second stage

    // next values of the chain
    always_comb
    begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    // register the chain
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= INIT;
            sync_r <= INIT;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule

// ---- core/ssrs_warn.sv ----
// sticky brownout warning flag for one supply
`timescale 1ns/1ps
module ssrs_warn
    import ssrs_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic below,
    input  wire logic clear,
    output logic      flag
);
    logic flag_r;     // sticky warning
    logic flag_nxt;   // next warning

    // set wins over clear so a dip is never lost
    always_comb
    begin
        flag_nxt = flag_r;
        if (clear)
        begin
            flag_nxt = 1'b0;
        end
        if (enable && below)
        begin
            flag_nxt = 1'b1;
        end
    end

    // register the flag
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            flag_r <= 1'b0;
        end
        else
        begin
            flag_r <= flag_nxt;
        end
    end

    assign flag = flag_r;
endmodule

// ---- core/ssrs_top.sv ----
// supply reset supervisor: reset line, power-up counter, warnings
// Contract
// - hold reset low once core supply above 1v
// - power-on threshold loads all power-on defaults
// - power-on clears core reset level to zero
// - power-up counter delays release 8.6 ms
// - release only stops driving line low
// - after release, fetch from reset vector
// - thresholds writable by software after reset
// - separate warning monitors for core, io
// - core warning raised before supply low reset
// - below reset level: pull line, halt, defaults
// - core reset level survives brownout reset
// - below reset level keeps reset asserted
// - brownout recovery skips counter, brownout defaults
// - below power-on threshold repeats full power-up
// - open-drain reset line, external low resets
`timescale 1ns/1ps
module ssrs_top
    import ssrs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        core_above_1v,
    input  wire logic        core_above_por,
    input  wire logic        core_above_reset,
    input  wire logic        core_above_warn,
    input  wire logic        io_above_warn,
    input  wire logic        reset_line_in,
    input  wire logic        rc_tick,
    input  wire logic        level_wr,
    input  wire logic [1:0]  core_warn_level_wd,
    input  wire logic [1:0]  io_warn_level_wd,
    input  wire logic [1:0]  core_reset_level_wd,
    input  wire logic        core_warn_clr,
    input  wire logic        io_warn_clr,
    output logic             reset_line_out,
    output logic             reset_line_oe,
    output logic             cpu_reset,
    output logic             por_defaults,
    output logic             bor_defaults,
    output logic [15:0]      fetch_addr,
    output logic             fetch_start,
    output logic [1:0]       core_warn_level,
    output logic [1:0]       io_warn_level,
    output logic [1:0]       core_reset_level,
    output logic             core_warn_irq,
    output logic             io_warn_irq,
    output logic             supply_warning_interrupt
);
    // synchronised comparator and pin levels
    logic        s_1v;            // core above 1v
    logic        s_por;           // core above power-on level
    logic        s_rst;           // core above reset level
    logic        s_cwarn;         // core above warning level
    logic        s_iwarn;         // io above warning level
    logic        s_pin;           // reset line level
    // supervisor state
    ssrs_state_e state_r;         // current state
    ssrs_state_e state_nxt;       // next state
    logic [PWRUP_CNT_W-1:0] cnt_r;   // power-up counter
    logic [PWRUP_CNT_W-1:0] cnt_nxt; // next counter
    logic        drive_r;         // driving reset line low
    logic        drive_nxt;
    logic        cpu_rst_r;       // processor held in reset
    logic        cpu_rst_nxt;
    logic        por_r;           // power-on default pulse
    logic        por_nxt;
    logic        bor_r;           // brownout default pulse
    logic        bor_nxt;
    logic        start_r;         // fetch start pulse
    logic        start_nxt;
    logic        pin_low_r;       // previous external low sample
    logic        pin_low_nxt;
    logic [SYNC_STAGES-1:0] drv_hist_r;   // recent drive, spans sync lag
    logic [SYNC_STAGES-1:0] drv_hist_nxt; // next drive history
    // threshold fields
    logic [1:0]  cwl_r;
    logic [1:0]  cwl_nxt;
    logic [1:0]  iwl_r;
    logic [1:0]  iwl_nxt;
    logic [1:0]  crl_r;
    logic [1:0]  crl_nxt;
    // warning flags and their registered copies
    logic        cw_flag;
    logic        iw_flag;
    logic        cw_irq_r;
    logic        iw_irq_r;
    logic        any_irq_r;
    logic        warn_en;         // warnings armed only while running
    logic        ext_low;         // someone else holds the line low

    // synchronisers for every asynchronous input
    ssrs_sync #(.INIT(1'b0)) u_s1v   (.clk(clk), .rst(rst),
        .async_in(core_above_1v), .sync_out(s_1v));
    ssrs_sync #(.INIT(1'b0)) u_spor  (.clk(clk), .rst(rst),
        .async_in(core_above_por), .sync_out(s_por));
    ssrs_sync #(.INIT(1'b0)) u_srst  (.clk(clk), .rst(rst),
        .async_in(core_above_reset), .sync_out(s_rst));
    ssrs_sync #(.INIT(1'b1)) u_scw   (.clk(clk), .rst(rst),
        .async_in(core_above_warn), .sync_out(s_cwarn));
    ssrs_sync #(.INIT(1'b1)) u_siw   (.clk(clk), .rst(rst),
        .async_in(io_above_warn), .sync_out(s_iwarn));
    ssrs_sync #(.INIT(1'b0)) u_spin  (.clk(clk), .rst(rst),
        .async_in(reset_line_in), .sync_out(s_pin));

    // line low while we are not driving means an external reset; the
    // drive history hides the synchroniser lag after our own release,
    // so an outside hold is seen only once that lag has passed
    assign ext_low = !s_pin && !drive_r && !(|drv_hist_r);
    assign warn_en = (state_r == SSRS_RUN) && s_rst;

    // sticky warning monitors, one per supply
    ssrs_warn u_cw (.clk(clk), .rst(rst), .enable(warn_en),
        .below(!s_cwarn), .clear(core_warn_clr),
        .flag(cw_flag));
    ssrs_warn u_iw (.clk(clk), .rst(rst), .enable(warn_en),
        .below(!s_iwarn), .clear(io_warn_clr),
        .flag(iw_flag));

    // supervisor sequencing: next state, counter, drive, pulses
    always_comb
    begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        drive_nxt   = drive_r;
        cpu_rst_nxt = cpu_rst_r;
        por_nxt     = 1'b0;
        bor_nxt     = 1'b0;
        start_nxt   = 1'b0;
        pin_low_nxt = ext_low;
        drv_hist_nxt = {drv_hist_r[SYNC_STAGES-2:0], drive_r};
        case (state_r)
            SSRS_OFF:
            begin
                // supply below power-on level; pull line low once above 1v
                drive_nxt   = s_1v;
                cpu_rst_nxt = 1'b1;
                if (s_por)
                begin
                    por_nxt   = 1'b1;
                    state_nxt = SSRS_POR;
                end
            end
            SSRS_POR:
            begin
                // wait for supply above reset level
                drive_nxt   = 1'b1;
                cpu_rst_nxt = 1'b1;
                cnt_nxt     = '0;
                if (!s_por)
                begin
                    state_nxt = SSRS_OFF;
                end
                else if (s_rst)
                begin
                    state_nxt = SSRS_COUNT;
                end
            end
            SSRS_COUNT:
            begin
                // power-up counter on the rc tick
                drive_nxt   = 1'b1;
                cpu_rst_nxt = 1'b1;
                if (!s_por)
                begin
                    state_nxt = SSRS_OFF;
                end
                else if (!s_rst)
                begin
                    state_nxt = SSRS_POR;
                end
                else if (rc_tick)
                begin
                    if (cnt_r == PWRUP_CNT_W'(PWRUP_CYCLES - 1))
                    begin
                        drive_nxt   = 1'b0;
                        cpu_rst_nxt = 1'b0;
                        start_nxt   = 1'b1;
                        state_nxt   = SSRS_RUN;
                    end
                    else
                    begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
            end
            SSRS_RUN:
            begin
                if (!s_por)
                begin
                    drive_nxt   = 1'b1;
                    cpu_rst_nxt = 1'b1;
                    state_nxt   = SSRS_OFF;
                end
                else if (!s_rst)
                begin
                    // brownout: hold everything in reset
                    drive_nxt   = 1'b1;
                    cpu_rst_nxt = 1'b1;
                    bor_nxt     = cpu_rst_r ? 1'b0 : 1'b1;
                end
                else if (ext_low)
                begin
                    cpu_rst_nxt = 1'b1;
                    drive_nxt   = 1'b0;
                end
                else if (cpu_rst_r)
                begin
                    // recovery without counter delay
                    drive_nxt   = 1'b0;
                    cpu_rst_nxt = 1'b0;
                    start_nxt   = 1'b1;
                    bor_nxt     = drive_r && !pin_low_r;
                end
            end
            default:
            begin
                state_nxt   = SSRS_OFF;
                drive_nxt   = 1'b1;
                cpu_rst_nxt = 1'b1;
            end
        endcase
    end

    // threshold fields and their default loading
    always_comb
    begin
        cwl_nxt = cwl_r;
        iwl_nxt = iwl_r;
        crl_nxt = crl_r;
        if (por_r || state_r == SSRS_OFF)
        begin
            cwl_nxt = CORE_WARN_POR;
            iwl_nxt = IO_WARN_POR;
            crl_nxt = CORE_RESET_POR;
        end
        else if (bor_r)
        begin
            cwl_nxt = CORE_WARN_POR;
            iwl_nxt = IO_WARN_POR;
            crl_nxt = crl_r;
        end
        else if (level_wr && !cpu_rst_r)
        begin
            cwl_nxt = core_warn_level_wd;
            iwl_nxt = io_warn_level_wd;
            crl_nxt = core_reset_level_wd;
        end
    end

    // register everything
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r   <= SSRS_OFF;
            cnt_r     <= '0;
            drive_r   <= 1'b1;
            cpu_rst_r <= 1'b1;
            por_r     <= 1'b0;
            bor_r     <= 1'b0;
            start_r   <= 1'b0;
            pin_low_r <= 1'b0;
            drv_hist_r <= '1;
            cwl_r     <= CORE_WARN_POR;
            iwl_r     <= IO_WARN_POR;
            crl_r     <= CORE_RESET_POR;
            cw_irq_r  <= 1'b0;
            iw_irq_r  <= 1'b0;
            any_irq_r <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            drive_r   <= drive_nxt;
            cpu_rst_r <= cpu_rst_nxt;
            por_r     <= por_nxt;
            bor_r     <= bor_nxt;
            start_r   <= start_nxt;
            pin_low_r <= pin_low_nxt;
            drv_hist_r <= drv_hist_nxt;
            cwl_r     <= cwl_nxt;
            iwl_r     <= iwl_nxt;
            crl_r     <= crl_nxt;
            cw_irq_r  <= cw_flag;
            iw_irq_r  <= iw_flag;
            any_irq_r <= cw_flag || iw_flag;
        end
    end

    // open drain: output always low, enable when pulling
    assign reset_line_out           = 1'b0;
    assign reset_line_oe            = drive_r;
    assign cpu_reset                = cpu_rst_r;
    assign por_defaults             = por_r;
    assign bor_defaults             = bor_r;
    assign fetch_addr               = RESET_VECTOR;
    assign fetch_start              = start_r;
    assign core_warn_level          = cwl_r;
    assign io_warn_level            = iwl_r;
    assign core_reset_level         = crl_r;
    assign core_warn_irq            = cw_irq_r;
    assign io_warn_irq              = iw_irq_r;
    assign supply_warning_interrupt = any_irq_r;
endmodule

// ---- dv/ssrs_asserts.sv ----
// port assertions for the supply reset supervisor
`timescale 1ns/1ps
module ssrs_chk
    import ssrs_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        core_above_1v,
    input wire logic        core_above_por,
    input wire logic        core_above_reset,
    input wire logic        core_above_warn,
    input wire logic        io_above_warn,
    input wire logic        rc_tick,
    input wire logic        core_warn_clr,
    input wire logic        reset_line_out,
    input wire logic        reset_line_oe,
    input wire logic        cpu_reset,
    input wire logic        por_defaults,
    input wire logic [15:0] fetch_addr,
    input wire logic        fetch_start,
    input wire logic [1:0]  core_reset_level,
    input wire logic        core_warn_irq,
    input wire logic        io_warn_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    int   cnt_r;  // oscillator ticks since power-on defaults
    logic pend_r; // power-up release still outstanding
    // count ticks between a power-on load and the release
    always_ff @(posedge clk)
    begin
        if (rst || por_defaults)
        begin
            cnt_r  <= 0;
            pend_r <= por_defaults;
        end
        else
        begin
            cnt_r  <= cnt_r + int'(rc_tick && pend_r);
            pend_r <= pend_r && cpu_reset;
        end
    end
    // supply held between the two reset levels
    sequence s_brown;
        (core_above_por && !core_above_reset)[*6];
    endsequence
    // running and under a warning level
    sequence s_cwarn;
        (!core_above_warn && core_above_reset && !cpu_reset)[*6];
    endsequence
    sequence s_iwarn;
        (!io_above_warn && core_above_reset && !cpu_reset)[*6];
    endsequence
    chk_line_low_only: assert property (reset_line_oe |-> !reset_line_out)
        else $error("reset line driven high");
    chk_oe_above_1v: assert property
        ((core_above_1v && !core_above_por)[*6] |-> reset_line_oe)
        else $error("reset line not held above 1 v");
    chk_por_zero: assert property (por_defaults |=> core_reset_level == 2'h0)
        else $error("power-on left reset level set");
    chk_release_fetch: assert property
        ($fell(cpu_reset) |-> fetch_start && fetch_addr == RESET_VECTOR)
        else $error("release without fetch from vector");
    chk_brown_pull: assert property (s_brown |-> reset_line_oe && cpu_reset)
        else $error("brownout not holding reset");
    chk_core_warn: assert property (s_cwarn |-> core_warn_irq)
        else $error("core warning missing");
    chk_io_warn: assert property (s_iwarn |-> io_warn_irq)
        else $error("io warning missing");
    chk_warn_sticky: assert property ($fell(core_warn_irq) |->
        $past(core_warn_clr, 2) || $past(cpu_reset) || cpu_reset)
        else $error("core warning dropped without clear");
    chk_pwrup_count: assert property
        ($fell(cpu_reset) && pend_r |-> cnt_r >= PWRUP_CYCLES)
        else $error("power-up release too early");
endmodule
bind ssrs_top ssrs_chk u_chk (.clk(clk), .rst(rst),
    .core_above_1v(core_above_1v), .core_above_por(core_above_por),
    .core_above_reset(core_above_reset), .core_above_warn(core_above_warn),
    .io_above_warn(io_above_warn), .rc_tick(rc_tick),
    .core_warn_clr(core_warn_clr), .reset_line_out(reset_line_out),
    .reset_line_oe(reset_line_oe), .cpu_reset(cpu_reset),
    .por_defaults(por_defaults), .fetch_addr(fetch_addr),
    .fetch_start(fetch_start), .core_reset_level(core_reset_level),
    .core_warn_irq(core_warn_irq), .io_warn_irq(io_warn_irq));

// ---- dv/ssrs_supply_model.sv ----
// supply comparators and pulled-up reset wire around the supervisor
`timescale 1ns/1ps
module ssrs_supply_model
#(
    parameter int RST_BASE  = 27, // tenths of a volt, reset level 0
    parameter int WARN_BASE = 30, // core warning at level 0
    parameter int IO_BASE   = 40  // io warning at level 0
)
(
    input  wire logic [7:0] core_v,  // core supply, tenths of a volt
    input  wire logic [7:0] io_v,    // io supply, tenths of a volt
    input  wire logic       ext_low, // outside party pulls the line
    input  wire logic       oe,      // supervisor pulls the line
    input  wire logic [1:0] cr_lvl,
    input  wire logic [1:0] cw_lvl,
    input  wire logic [1:0] iw_lvl,
    output logic            a1v,
    output logic            apor,
    output logic            arst,
    output logic            awarn,
    output logic            aio,
    output logic            line
);
    // reset and warning comparators follow the selected levels
    assign a1v   = core_v >= 8'h0a;
    assign apor  = core_v >= 8'h0c;
    assign arst  = int'(core_v) >= RST_BASE + int'(cr_lvl);
    assign awarn = int'(core_v) >= WARN_BASE + int'(cw_lvl);
    assign aio   = int'(io_v) >= IO_BASE + int'(iw_lvl);
    // pull-up wins only when nobody pulls low
    assign line  = !(oe || ext_low);
endmodule

// ---- dv/ssrs_top_tb.sv ----
// self-checking bench for the supply reset supervisor
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module ssrs_top_tb
    import ssrs_pkg::*;
;
    logic        clk = 0;
    logic        rst = 1;
    logic [7:0]  core_v, io_v;
    logic        ext_low, rc_tick, level_wr, cw_clr, iw_clr;
    logic [1:0]  cw, iw, cr;
    logic        a1v, apor, arst, awarn, aio, line_in;
    logic        line_out, oe, cpu_rst, por_d, bor_d, fstart;
    logic        cw_irq, iw_irq, swi;
    logic [15:0] faddr;
    logic [1:0]  cw_lvl, iw_lvl, cr_lvl;
    int          n_fail, tests_run, seed, n, i;
    int          n_start = 0;   // fetch start pulses seen
    int          n_bor   = 0;   // brownout default pulses seen
    int          n_por   = 0;   // power-on default pulses seen
    // free-running 200 MHz clock
    always #2.5 clk = ~clk;
    ssrs_supply_model u_sup (.core_v(core_v), .io_v(io_v),
        .ext_low(ext_low), .oe(oe), .cr_lvl(cr_lvl), .cw_lvl(cw_lvl),
        .iw_lvl(iw_lvl), .a1v(a1v), .apor(apor), .arst(arst),
        .awarn(awarn), .aio(aio), .line(line_in));
    ssrs_top u_dut (.clk(clk), .rst(rst), .core_above_1v(a1v),
        .core_above_por(apor), .core_above_reset(arst),
        .core_above_warn(awarn), .io_above_warn(aio),
        .reset_line_in(line_in), .rc_tick(rc_tick), .level_wr(level_wr),
        .core_warn_level_wd(cw), .io_warn_level_wd(iw),
        .core_reset_level_wd(cr), .core_warn_clr(cw_clr),
        .io_warn_clr(iw_clr), .reset_line_out(line_out),
        .reset_line_oe(oe), .cpu_reset(cpu_rst), .por_defaults(por_d),
        .bor_defaults(bor_d), .fetch_addr(faddr), .fetch_start(fstart),
        .core_warn_level(cw_lvl), .io_warn_level(iw_lvl),
        .core_reset_level(cr_lvl), .core_warn_irq(cw_irq),
        .io_warn_irq(iw_irq), .supply_warning_interrupt(swi));
    // count the one-cycle pulses while they stand
    always @(negedge clk)
    begin
        if (!rst)
        begin
            n_start += int'(fstart);
            n_bor   += int'(bor_d);
            n_por   += int'(por_d);
        end
    end
    // print counts and verdict, then stop
    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // bounded wait for the processor reset level
    task wait_cpu(input logic want, input int lim);
        n = 0;
        while (cpu_rst !== want)
        begin
            if (n == lim)
            begin
                n_fail++;
                end_sim;
            end
            n++;
            @(negedge clk);
        end
    endtask
    // one-cycle level write
    task wr;
        level_wr = 1;
        @(negedge clk);
        level_wr = 0;
        @(negedge clk);
    endtask
    // main sequence
    initial
    begin
        {n_fail, tests_run, seed} = {32'd0, 32'd0, 32'd8};
        {core_v, io_v, ext_low, rc_tick} = {8'h00, 8'h32, 1'b0, 1'b1};
        {level_wr, cw_clr, iw_clr, cw, iw, cr} = 9'h000;
        repeat (8) @(negedge clk);
        rst = 0;
        core_v = 8'h0a;
        repeat (6) @(negedge clk);
        `CHK(line_in, 1'b0)
        core_v = 8'h21;
        wait_cpu(1'b0, 70000);
        `CHK(n >= PWRUP_CYCLES && n <= PWRUP_CYCLES + 8, 1'b1)
        `CHK({cr_lvl, cw_lvl}, {CORE_RESET_POR, CORE_WARN_POR})
        `CHK(faddr, RESET_VECTOR)
        `CHK(line_in, 1'b1)
        cw = 2'($random(seed));
        iw = 2'($random(seed));
        cr = 2'h1 + 2'($random(seed) & 1);
        wr;
        `CHK({cw_lvl, iw_lvl, cr_lvl}, {cw, iw, cr})
        // core then io supply dips under its warning level
        for (i = 0; i < 2; i++)
        begin
            if (i == 0)
                core_v = 8'(29 + cw);
            else
                io_v = 8'(39 + iw);
            repeat (8) @(negedge clk);
            `CHK({cw_irq, iw_irq, swi}, i == 0 ? 3'h5 : 3'h3)
            `CHK(cpu_rst, 1'b0)
            {core_v, io_v} = {8'h21, 8'h32};
            repeat (8) @(negedge clk);
            `CHK(swi, 1'b1)
            {cw_clr, iw_clr} = i == 0 ? 2'h2 : 2'h1;
            @(negedge clk);
            {cw_clr, iw_clr} = 2'h0;
            repeat (4) @(negedge clk);
            `CHK({cw_irq, iw_irq, swi}, 3'h0)
        end
        ext_low = 1;
        repeat (6) @(negedge clk);
        `CHK({cpu_rst, oe}, 2'h2)
        ext_low = 0;
        wait_cpu(1'b0, 20);
        core_v = 8'h14;
        repeat (20) @(negedge clk);
        `CHK({cpu_rst, oe, line_in}, 3'h6)
        `CHK({cr_lvl, cw_lvl}, {cr, 2'h0})
        cr = ~cr;
        wr;
        `CHK(cr_lvl, ~cr)
        core_v = 8'h21;
        wait_cpu(1'b0, 20);
        `CHK(cr_lvl, ~cr)
        core_v = 8'h0b;
        repeat (10) @(negedge clk);
        `CHK({cr_lvl, oe}, 3'h1)
        core_v = 8'h21;
        repeat (1000) @(negedge clk);
        `CHK(cpu_rst, 1'b1)
        `CHK(n_start, 3)
        `CHK(n_bor, 2)
        `CHK(n_por, 2)
        end_sim;
    end
endmodule
